// >>> include/dpfm_consts.svh
// Purpose: Named constants for the pin-function mux
// Assumes: Included by bare name
// Notes: Bit positions within the flag and mode vectors
`ifndef DPFM_CONSTS_SVH
`define DPFM_CONSTS_SVH
`define DPFM_MODE_A 0
`define DPFM_MODE_B 1
`define DPFM_MODE_C 2
`define DPFM_MODE_D 3
`define DPFM_FLAG_IRQ_EDGE_ONLY 4
`define DPFM_FLAG_IRQ_LEVEL_LOW_0 5
`define DPFM_FLAG_IRQ_LEVEL_LOW_1 6
`define DPFM_FLAG_IRQ_EDGE_OR_LEVEL_2 7
`define DPFM_IRQ_SRC_IRQ_EDGE_ONLY 0
`define DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0 1
`define DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1 2
`define DPFM_IRQ_SRC_IRQ_EDGE_OR_LEVEL_2 3
`define DPFM_IRQ_SRC_SP0 4
`define DPFM_IRQ_SRC_SP1 5
`define DPFM_SEL_PRIMARY 1'h0
`define DPFM_SEL_ALTERNATE 1'h1
`endif

// >>> include/dpfm_pkg.sv
// Purpose: Types for the pin-function mux
// Assumes: Nothing
// Notes: Bus-configuration mode taken from mode input C
package dpfm_pkg;
  typedef enum logic [1:0] {
    DPFM_FULL_MEMORY = 2'h1,
    DPFM_HOST = 2'h2
  } dpfm_bus_mode_type;
endpackage

// >>> logic/dpfm_irq_detect.sv
// Purpose: One interrupt request detector, edge or level sensing
// Assumes: Pin active low, synchronous to the clock
// Notes: Edge latch is cleared by the sequencer acknowledge
`include "dpfm_consts.svh"
module dpfm_irq_detect (
  input wire logic i_clk_sys, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_pin_n, // Request level, active low
  input wire logic i_edge_mode, // 1 = falling edge sense
  input wire logic i_ack, // Clears a latched edge
  output logic o_req // Request pending
);
  logic prev_q;
  logic edge_q;
  logic fall;
  assign fall = prev_q & ~i_pin_n;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q <= 1'h1;
    end else begin
      prev_q <= i_pin_n;
    end
  end
  // Set wins over acknowledge so no edge is lost
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_q <= 1'h0;
    end else if (fall) begin
      edge_q <= 1'h1;
    end else if (i_ack) begin
      edge_q <= 1'h0;
    end
  end
  assign o_req = i_edge_mode ? edge_q : ~i_pin_n;
endmodule

// >>> logic/dpfm_pin_mux.sv
// Purpose: Shared pin-function multiplexing for boot, flag and IRQ pins
// Assumes: Pin levels synchronous to i_clk_sys; pins active low for IRQ
// Notes: Pin wire level is resolved outside from output enables
// How it works
// - Bus pin function fixed only at reset
// - Serial pin function changeable at run time
// - Shared pins act as flag and IRQ
// - Boot-mode inputs sampled only at the first clock after reset release
// - After reset mode pins are flags 0-3
// - IRQ_EDGE_OR_LEVEL_2 and both serial port IRQs selectable sense; others fixed sense
// - Own flag drive also raises interrupt
// - Control field selects serial port function
// - Reset leaves pins in primary function
// - Mode C low full memory, high host
// - Alternate: two IRQs, flag in, flag out
`include "dpfm_consts.svh"
module dpfm_pin_mux #(
  parameter int NFLAG = 8, // Programmable flag pins
  parameter int NIRQ = 6 // External interrupt sources
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [NFLAG-1:0] i_gp_flag, // Flag pin levels
  input wire logic [NFLAG-1:0] i_flag_dir, // 1 = flag is output
  input wire logic [NFLAG-1:0] i_flag_wdata, // Flag output values
  output logic [NFLAG-1:0] o_gp_flag, // Flag pin drive value
  output logic [NFLAG-1:0] o_gp_flag_oe, // Flag pin drive enable
  output logic [NFLAG-1:0] o_flag_rdata, // Flag levels seen
  input wire logic i_irq_edge_or_level_2_edge_mode, // Sense for irq_edge_or_level_2
  input wire logic [NIRQ-1:0] i_interrupt_mask_reg, // Enable per source
  input wire logic [NIRQ-1:0] i_irq_ack, // Sequencer acknowledge
  output logic [NIRQ-1:0] o_irq_vector_req, // Enabled pending requests
  input wire logic i_sport_alt_sel, // Control field: 1 = alternate
  input wire logic [1:0] i_sport_irq_n, // Second serial port IRQ pins
  input wire logic i_sport_dr, // Receive data pin level
  input wire logic i_sport_core_dt, // Serial port transmit data
  input wire logic i_sport_sclk_int, // Internal serial clock
  input wire logic i_flag_out_val, // Value for flag_out pin
  output logic o_sport_dt, // Transmit data pin drive
  output logic o_sport_sclk, // Serial clock pin drive
  output logic o_sport_dr_core, // Receive data to serial port
  output logic o_flag_in, // flag_in level
  output logic o_sport_alt_q, // Active serial pin function
  output dpfm_pkg::dpfm_bus_mode_type o_bus_mode, // Bus mode
  output logic [3:0] o_boot_mode // Latched mode A..D
);
  logic run_q;
  logic [3:0] boot_q;
  logic alt_q;
  logic [NFLAG-1:0] seen;
  logic [NIRQ-1:0] pin_n;
  logic [NIRQ-1:0] edge_mode;
  logic [NIRQ-1:0] pend;
  dpfm_pkg::dpfm_bus_mode_type bus_q;

  // Mode pins are inputs while reset holds; run_q marks the first cycle
  // after release, which is when the straps are captured.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q <= 1'h0;
    end else begin
      run_q <= 1'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_q <= 4'h0;
    end else if (!run_q) begin
      boot_q <= i_gp_flag[`DPFM_MODE_D:`DPFM_MODE_A];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_q <= dpfm_pkg::DPFM_FULL_MEMORY;
    end else if (!run_q) begin
      bus_q <= i_gp_flag[`DPFM_MODE_C] ? dpfm_pkg::DPFM_HOST
                                       : dpfm_pkg::DPFM_FULL_MEMORY;
    end
  end
  assign o_bus_mode = bus_q;
  assign o_boot_mode = boot_q;

  // Flags never drive before the straps are taken, keeping mode pins inputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gp_flag <= '0;
      o_gp_flag_oe <= '0;
    end else begin
      o_gp_flag <= i_flag_wdata;
      o_gp_flag_oe <= run_q ? i_flag_dir : '0;
    end
  end

  // Read-back follows own drive so self-driven flags still interrupt
  assign seen = (o_gp_flag_oe & o_gp_flag) | (~o_gp_flag_oe & i_gp_flag);
  assign o_flag_rdata = seen;

  // Serial port function register, primary after reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      alt_q <= `DPFM_SEL_PRIMARY;
    end else begin
      alt_q <= i_sport_alt_sel;
    end
  end
  assign o_sport_alt_q = alt_q;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sport_dt <= 1'h0;
      o_flag_in <= 1'h0;
    end else begin
      o_sport_dt <= alt_q ? i_flag_out_val : i_sport_core_dt;
      o_flag_in <= alt_q ? i_sport_dr : 1'h0;
    end
  end
  assign o_sport_dr_core = alt_q ? 1'h0 : i_sport_dr;
  assign o_sport_sclk = i_sport_sclk_int;

  // Source order: edge-only, level 0, level 1, configurable 2, port 0, 1
  assign pin_n[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY] = seen[`DPFM_FLAG_IRQ_EDGE_ONLY];
  assign pin_n[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0] = seen[`DPFM_FLAG_IRQ_LEVEL_LOW_0];
  assign pin_n[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1] = seen[`DPFM_FLAG_IRQ_LEVEL_LOW_1];
  assign pin_n[`DPFM_IRQ_SRC_IRQ_EDGE_OR_LEVEL_2] = seen[`DPFM_FLAG_IRQ_EDGE_OR_LEVEL_2];
  assign pin_n[`DPFM_IRQ_SRC_SP0] = alt_q ? i_sport_irq_n[0] : 1'h1;
  assign pin_n[`DPFM_IRQ_SRC_SP1] = alt_q ? i_sport_irq_n[1] : 1'h1;
  assign edge_mode[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY] = 1'h1;
  assign edge_mode[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0] = 1'h0;
  assign edge_mode[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1] = 1'h0;
  assign edge_mode[`DPFM_IRQ_SRC_IRQ_EDGE_OR_LEVEL_2] = i_irq_edge_or_level_2_edge_mode;
  assign edge_mode[`DPFM_IRQ_SRC_SP0] = i_irq_edge_or_level_2_edge_mode;
  assign edge_mode[`DPFM_IRQ_SRC_SP1] = i_irq_edge_or_level_2_edge_mode;

  genvar g;
  generate
    for (g = 0; g < NIRQ; g++) begin : g_irq
      dpfm_irq_detect u_det (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin_n(pin_n[g]),
        .i_edge_mode(edge_mode[g]),
        .i_ack(i_irq_ack[g]),
        .o_req(pend[g])
      );
    end
  endgenerate

  assign o_irq_vector_req = pend & i_interrupt_mask_reg;

  // Assertions
  chk_mode_hold: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    $past(run_q) |-> $stable(o_bus_mode))
    else $error("bus mode changed while running");
  chk_boot_hold: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    $past(run_q) |-> $stable(o_boot_mode))
    else $error("boot mode changed while running");
  chk_mode_c: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !run_q ##1 run_q |-> (o_bus_mode == dpfm_pkg::DPFM_HOST)
      == o_boot_mode[`DPFM_MODE_C])
    else $error("bus mode does not follow mode C");
  chk_flag_oe: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    run_q |=> o_gp_flag_oe == $past(i_flag_dir))
    else $error("flag direction not applied");
  chk_sport_sel: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    run_q |=> o_sport_alt_q == $past(i_sport_alt_sel))
    else $error("serial port function not updated");
  chk_alt_out: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    o_sport_alt_q |=> o_sport_dt == $past(i_flag_out_val))
    else $error("flag_out not driven in alternate mode");
  chk_self_irq: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    o_gp_flag_oe[`DPFM_FLAG_IRQ_LEVEL_LOW_0] && !o_gp_flag[`DPFM_FLAG_IRQ_LEVEL_LOW_0]
      && i_interrupt_mask_reg[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0]
      |-> o_irq_vector_req[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0])
    else $error("self-driven flag did not interrupt");
  chk_mask_gate: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (o_irq_vector_req & ~i_interrupt_mask_reg) == '0)
    else $error("masked interrupt raised");
  chk_level_irq: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    seen[`DPFM_FLAG_IRQ_LEVEL_LOW_1] && i_interrupt_mask_reg[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1]
      |-> !o_irq_vector_req[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1])
    else $error("level request without low level");
  chk_edge_sticky: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    pend[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY] && !i_irq_ack[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY]
      |=> pend[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY])
    else $error("edge request lost before acknowledge");
  chk_level_follow: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    pend[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_0] == !seen[`DPFM_FLAG_IRQ_LEVEL_LOW_0])
    else $error("level request does not follow pin");
  chk_primary_dr: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !o_sport_alt_q |-> o_sport_dr_core == i_sport_dr)
    else $error("receive data not routed in primary mode");
  chk_alt_flag_in: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    o_sport_alt_q |=> o_flag_in == $past(i_sport_dr))
    else $error("flag_in not taken in alternate mode");
  chk_straps_undriven: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !run_q |-> o_gp_flag_oe == '0)
    else $error("mode pins driven before straps taken");
  cov_host: cover property (@(posedge i_clk_sys)
    run_q && o_bus_mode == dpfm_pkg::DPFM_HOST);
  cov_alt: cover property (@(posedge i_clk_sys)
    !o_sport_alt_q ##1 o_sport_alt_q);
  cov_edge_irq: cover property (@(posedge i_clk_sys)
    o_irq_vector_req[`DPFM_IRQ_SRC_IRQ_EDGE_ONLY]);
  cov_full_mem: cover property (@(posedge i_clk_sys)
    !run_q ##1 run_q && o_bus_mode == dpfm_pkg::DPFM_FULL_MEMORY);
  cov_self_irq: cover property (@(posedge i_clk_sys)
    o_gp_flag_oe[`DPFM_FLAG_IRQ_LEVEL_LOW_1] && o_irq_vector_req[`DPFM_IRQ_SRC_IRQ_LEVEL_LOW_1]);
endmodule

// >>> tb/dpfm_ext_pins.sv
// Purpose: Far-side model of the shared flag and interrupt pins
// Assumes: Every pin has a pull-up
// Notes: Device drive wins over the far side
module dpfm_ext_pins (
  input wire logic [7:0] i_oe, // Device drive enable
  input wire logic [7:0] i_drv, // Device drive value
  input wire logic [7:0] i_ext_en, // Far side drives
  input wire logic [7:0] i_ext_val, // Far side value
  output logic [7:0] o_pin // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin goes to the pull-up, never keeps its last value
  assign o_pin = (i_oe & i_drv) |
    (~i_oe & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule

// >>> tb/dpfm_pin_mux_bench.sv
// Purpose: Self-checking bench for the pin-function mux
// Assumes: 40 MHz clock, pins pulled up in the pin model
// Notes: Inputs change on the rising edge by non-blocking assignment
module dpfm_pin_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'h0;
  logic i_resetn = 1'h0;
  logic [7:0] gp_flag, gp_out, gp_oe, rdata;
  logic [7:0] flag_dir = 8'h00, flag_wdata = 8'h00;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'hF4;
  logic [5:0] mask = 6'h3F, ack = 6'h00, req;
  logic irq_edge_or_level_2_edge = 1'h0, alt_sel = 1'h0, dr = 1'h0, core_dt = 1'h0;
  logic sclk_int = 1'h0, fo_val = 1'h0, dt, sclk, dr_core, fl_in, alt_q;
  logic [1:0] sp_irq_n = 2'h3;
  logic [3:0] boot;
  dpfm_pkg::dpfm_bus_mode_type bus_mode;
  int bad_count = 0, checked = 0, cycles = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  dpfm_pin_mux #(.NFLAG(8), .NIRQ(6)) dpfm_pin_mux_inst (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_gp_flag(gp_flag),
    .i_flag_dir(flag_dir), .i_flag_wdata(flag_wdata), .o_gp_flag(gp_out),
    .o_gp_flag_oe(gp_oe), .o_flag_rdata(rdata),
    .i_irq_edge_or_level_2_edge_mode(irq_edge_or_level_2_edge), .i_interrupt_mask_reg(mask),
    .i_irq_ack(ack), .o_irq_vector_req(req), .i_sport_alt_sel(alt_sel),
    .i_sport_irq_n(sp_irq_n), .i_sport_dr(dr), .i_sport_core_dt(core_dt),
    .i_sport_sclk_int(sclk_int), .i_flag_out_val(fo_val), .o_sport_dt(dt),
    .o_sport_sclk(sclk), .o_sport_dr_core(dr_core), .o_flag_in(fl_in),
    .o_sport_alt_q(alt_q), .o_bus_mode(bus_mode), .o_boot_mode(boot));
  dpfm_ext_pins dpfm_ext_pins_inst (.i_oe(gp_oe), .i_drv(gp_out),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(gp_flag));
  task go(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Straps move right after they are taken, to show they are frozen
  task rst(input logic [3:0] straps);
    @(posedge i_clk_sys);
    i_resetn <= 1'h0;
    ext_val <= {4'hF, straps};
    go(11);
    chk("oe in reset", 8'h00, gp_oe);
    chk("alt in reset", 8'h00, {7'h0, alt_q});
    chk("bus in reset", 8'h01, 8'(bus_mode));
    @(posedge i_clk_sys);
    i_resetn <= 1'h1;
    go(1);
    @(posedge i_clk_sys);
    ext_val[3:0] <= ~straps;
    go(2);
    chk("boot mode", {4'h0, straps}, {4'h0, boot});
    chk("bus mode", straps[2] ? 8'h02 : 8'h01, 8'(bus_mode));
  endtask
  task sp(input logic a, input logic [7:0] e);
    @(posedge i_clk_sys);
    alt_sel <= a;
    go(2);
    chk("sport pins", e, {3'h0, alt_q, dt, fl_in, dr_core, sclk});
    chk("sport irq", a ? 8'h30 : 8'h00, {2'h0, req});
  endtask
  initial begin
    rst(4'h4);
    @(posedge i_clk_sys);
    flag_dir <= 8'h0F;
    flag_wdata <= 8'h05;
    go(1);
    chk("flag oe", 8'h0F, gp_oe);
    chk("flag drive", 8'h05, {4'h0, gp_out[3:0]});
    chk("flag read", 8'h05, {4'h0, rdata[3:0]});
    @(posedge i_clk_sys);
    flag_dir <= 8'h00;
    ext_val[3:0] <= 4'hA;
    go(1);
    chk("flag input", 8'h0A, {4'h0, rdata[3:0]});
    chk("boot kept", 8'h04, {4'h0, boot});
    @(posedge i_clk_sys);
    ext_val[6:5] <= 2'h0;
    go(0);
    chk("level req", 8'h06, {2'h0, req});
    chk("level flags", 8'h00, {6'h0, rdata[6:5]});
    @(posedge i_clk_sys);
    mask <= 6'h39;
    go(0);
    chk("masked req", 8'h00, {2'h0, req});
    @(posedge i_clk_sys);
    mask <= 6'h3F;
    ext_val[6:5] <= 2'h3;
    go(0);
    chk("level gone", 8'h00, {2'h0, req});
    @(posedge i_clk_sys);
    ext_val[7] <= 1'h0;
    ext_val[4] <= 1'h0;
    irq_edge_or_level_2_edge <= 1'h1;
    @(posedge i_clk_sys);
    ext_val[7] <= 1'h1;
    ext_val[4] <= 1'h1;
    go(2);
    chk("edge held", 8'h09, {2'h0, req});
    @(posedge i_clk_sys);
    ack <= 6'h09;
    @(posedge i_clk_sys);
    ack <= 6'h00;
    irq_edge_or_level_2_edge <= 1'h0;
    ext_val[7] <= 1'h0;
    go(0);
    chk("ack and level", 8'h08, {2'h0, req});
    @(posedge i_clk_sys);
    ext_val[7] <= 1'h1;
    flag_dir <= 8'h40;
    flag_wdata <= 8'h00;
    go(1);
    chk("self drive", 8'h04, {2'h0, req});
    @(posedge i_clk_sys);
    flag_dir <= 8'h0F;
    dr <= 1'h1;
    core_dt <= 1'h1;
    sclk_int <= 1'h1;
    sp_irq_n <= 2'h0;
    sp(1'h0, 8'h0B);
    sp(1'h1, 8'h15);
    sp(1'h0, 8'h0B);
    sp(1'h1, 8'h15);
    rst(4'hB);
    test_done();
  end
  // Whole run needs about 62 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 600) begin
      bad_count++;
      test_done();
    end
  end
endmodule
